// [logic/csp_consts.svh]
// Register offsets, field positions, reset values and the overrun bit number for the serial port
`ifndef CSP_CONSTS_SVH
`define CSP_CONSTS_SVH
`define CSP_OFF_TXBUF     12'h000
`define CSP_OFF_RXBUF     12'h004
`define CSP_OFF_DIV       12'h008
`define CSP_OFF_MODE      12'h00c
`define CSP_OFF_CTRL0     12'h010
`define CSP_OFF_CTRL1     12'h014
`define CSP_OFF_CLKSEL    12'h018
`define CSP_MODE_SYNC     3'h1
`define CSP_OVR_BIT       12
`define CSP_DIV_RST       8'h00
`define CSP_MODE_RST      8'h00
`define CSP_CTRL0_RST     8'h08
`define CSP_CTRL1_RST     8'h02
`define CSP_CLKSEL_RST    8'h00
`define CSP_OVR_BITNUM    4'h7
`endif

// [logic/csp_pkg.sv]
// Types shared by the serial port
package csp_pkg;
	typedef enum logic [2:0] {
		CSP_IDLE = 3'b001,
		CSP_RUN  = 3'b010,
		CSP_DONE = 3'b100
	} csp_state_t;
	typedef struct packed {
		logic       clock_direction_select;
		logic       clock_polarity_select;
		logic       clock_phase_select;
		logic       msb_first;
		logic       invert;
		logic       rrm;
		logic       irs;
		logic [2:0] mode;
	} csp_cfg_t;
	typedef struct packed {
		logic sck_o;
		logic sck_oen;
		logic sdo_o;
		logic sdo_oen;
	} csp_pins_t;
endpackage

// [logic/csp_port.sv]
// Clock-synchronous serial port, master or slave, with APB register access
`timescale 1ns/1ps
`include "csp_consts.svh"
module csp_port
	import csp_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        clk_en,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        serial_clock_pin_i,
	output logic             serial_clock_pin_o,
	output logic             serial_clock_pin_oen,
	input  wire logic        serial_data_in_pin,
	output logic             serial_data_out_pin_o,
	output logic             serial_data_out_pin_oen,
	output logic             tx_event,
	output logic             rx_event
);
	logic [7:0] bit_rate_divider_ff, nxt_bit_rate_divider;
	logic [7:0] mode_ff, nxt_mode, ctrl0_ff, nxt_ctrl0, ctrl1_ff, nxt_ctrl1, clksel_ff, nxt_clksel;
	logic [7:0] transmit_buffer_ff, nxt_transmit_buffer, receive_buffer_ff, nxt_receive_buffer;
	logic [7:0] shift_ff, nxt_shift;
	logic [3:0] cnt_ff, nxt_cnt;
	logic [7:0] div_ff, nxt_div;
	logic [4:0] pre_ff, nxt_pre;
	logic       sck_ff, nxt_sck, sdo_ff, nxt_sdo, overrun_flag_ff, nxt_overrun;
	logic       tx_buffer_empty_flag_ff, nxt_tbe, rx_complete_flag_ff, nxt_rxc, rx_armed_ff, nxt_rx_armed;
	logic       txev_ff, nxt_txev, rxev_ff, nxt_rxev, rdy_ff, nxt_rdy, err_ff, nxt_err;
	logic [31:0] prdata_ff, nxt_prdata;
	logic [2:0] sck_sync_ff, sdi_sync_ff;
	csp_state_t st_ff, nxt_st;
	csp_cfg_t   cfg;
	logic       tx_shift_empty_flag, tick, sck_in, lead_edge, trail_edge, sdi, apb_acc, rd_rx, rxen;

	function automatic logic sel_bit(input logic [7:0] v, input logic msb, input logic [3:0] n);
		sel_bit = msb ? v[3'd7 - n[2:0]] : v[n[2:0]];
	endfunction

	assign cfg = '{clock_direction_select: mode_ff[3], clock_polarity_select: ctrl0_ff[6], clock_phase_select: ctrl1_ff[6], msb_first: ctrl0_ff[7],
		invert: ctrl1_ff[7], rrm: ctrl1_ff[5], irs: ctrl1_ff[4], mode: mode_ff[2:0]};
	assign apb_acc = psel & penable & ~rdy_ff;
	assign rd_rx = apb_acc & ~pwrite & (paddr == `CSP_OFF_RXBUF);
	assign rxen = ctrl1_ff[2] & ctrl1_ff[0];
	assign tx_shift_empty_flag = (st_ff == CSP_IDLE);
	assign sck_in = sck_sync_ff[1];
	assign sdi = sdi_sync_ff[1] ^ cfg.invert;

	// Pin synchronisers, edge detect reads second and third stage only
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sck_sync_ff <= 3'h0;
			sdi_sync_ff <= 3'h0;
		end
		else if (clk_en)
		begin
			sck_sync_ff <= {sck_sync_ff[1:0], serial_clock_pin_i};
			sdi_sync_ff <= {sdi_sync_ff[1:0], serial_data_in_pin};
		end
	end

	// count source select; base clock, stopped prescaler freezes it
	always_comb
	begin
		nxt_pre = clksel_ff[2] ? pre_ff : 5'(pre_ff + 5'h1);
		unique case (clksel_ff[1:0])
			2'h0: tick = ~clksel_ff[2];
			2'h1: tick = pre_ff[0] & ~clksel_ff[2];
			default: tick = (&pre_ff) & ~clksel_ff[2];
		endcase
	end

	// Edges in serial clock terms: leading edge shifts out for phase 0
	always_comb
	begin
		logic edge_r;
		logic edge_f;
		edge_r = sck_in & ~sck_sync_ff[2];
		edge_f = ~sck_in & sck_sync_ff[2];
		if (cfg.clock_direction_select)
		begin
			lead_edge = cfg.clock_polarity_select ? edge_r : edge_f;
			trail_edge = cfg.clock_polarity_select ? edge_f : edge_r;
		end
		else
		begin
			// half period of (n+1) source ticks
			lead_edge = tick & (div_ff == 8'h00) & (sck_ff == ~cfg.clock_polarity_select) & (st_ff == CSP_RUN);
			trail_edge = tick & (div_ff == 8'h00) & (sck_ff == cfg.clock_polarity_select) & (st_ff == CSP_RUN);
		end
	end

	// Transfer engine
	always_comb
	begin
		logic samp;
		logic shout;
		samp = cfg.clock_phase_select ? lead_edge : trail_edge;
		shout = cfg.clock_phase_select ? trail_edge : lead_edge;
		nxt_st = st_ff;
		nxt_shift = shift_ff;
		nxt_cnt = cnt_ff;
		nxt_div = div_ff;
		nxt_sck = sck_ff;
		nxt_sdo = sdo_ff;
		nxt_tbe = tx_buffer_empty_flag_ff;
		nxt_rxc = rx_complete_flag_ff;
		// Overrun clears only on a receive buffer read; a read in the same cycle blocks a new overrun
		nxt_overrun = overrun_flag_ff & ~rd_rx;
		nxt_receive_buffer = receive_buffer_ff;
		nxt_rx_armed = rx_armed_ff;
		nxt_txev = 1'b0;
		nxt_rxev = 1'b0;
		if (!cfg.clock_direction_select && st_ff == CSP_RUN && tick)
		begin
			nxt_div = (div_ff == 8'h00) ? bit_rate_divider_ff : 8'(div_ff - 8'h1);
			if (div_ff == 8'h00)
				nxt_sck = ~sck_ff;
		end
		// read of receive buffer re-arms in continuous mode
		if (rd_rx)
		begin
			nxt_rxc = 1'b0;
			if (cfg.rrm)
				nxt_rx_armed = 1'b1;
		end
		unique case (st_ff)
			CSP_IDLE:
			begin
				nxt_sck = cfg.clock_polarity_select;
				// start only with transmit enabled and data present; mode check
				if (ctrl1_ff[0] && !tx_buffer_empty_flag_ff && cfg.mode == `CSP_MODE_SYNC)
				begin
					nxt_st = CSP_RUN;
					nxt_shift = transmit_buffer_ff ^ {8{cfg.invert}};
					nxt_tbe = 1'b1;
					nxt_cnt = 4'h0;
					nxt_div = bit_rate_divider_ff;
					// event on buffer move when selector clear; selector
					nxt_txev = ~cfg.irs;
					// first bit out at load, phase 0 only
					if (!cfg.clock_phase_select)
						nxt_sdo = sel_bit(transmit_buffer_ff ^ {8{cfg.invert}}, cfg.msb_first, 4'h0);
				end
			end
			CSP_RUN:
			begin
				if (shout && !cnt_ff[3] && (cfg.clock_phase_select || cnt_ff != 4'h0))
					nxt_sdo = sel_bit(shift_ff, cfg.msb_first, cnt_ff);
				if (samp && !cnt_ff[3])
				begin
					// fill position by bit order; inversion applied at sdi
					if (cfg.msb_first)
						nxt_shift[3'd7 - cnt_ff[2:0]] = sdi;
					else
						nxt_shift[cnt_ff[2:0]] = sdi;
					nxt_cnt = 4'(cnt_ff + 4'h1);
					// seventh bit while previous word unread
					if (cnt_ff == 4'(`CSP_OVR_BITNUM - 4'h1) && rx_complete_flag_ff && rxen && !rd_rx)
						nxt_overrun = 1'b1;
					if (cnt_ff == 4'h7 && cfg.clock_phase_select)
						nxt_st = CSP_DONE;
				end
				// Phase 0 keeps the last half period before the clock returns to idle
				if (shout && cnt_ff[3])
					nxt_st = CSP_DONE;
			end
			default:
			begin
				nxt_st = CSP_IDLE;
				nxt_sck = cfg.clock_polarity_select;
				nxt_txev = cfg.irs;
				// receive only when both enables set
				if (rxen && (rx_armed_ff || !cfg.rrm))
				begin
					nxt_receive_buffer = shift_ff;
					nxt_rxc = 1'b1;
					nxt_rxev = 1'b1;
					nxt_rx_armed = ~cfg.rrm;
				end
			end
		endcase
		// Software write fills the buffer; it wins over a load in the same cycle
		if (apb_acc && pwrite && paddr == `CSP_OFF_TXBUF)
			nxt_tbe = 1'b0;
	end

	// APB register side
	always_comb
	begin
		nxt_bit_rate_divider = bit_rate_divider_ff;
		nxt_mode = mode_ff;
		nxt_ctrl0 = ctrl0_ff;
		nxt_ctrl1 = ctrl1_ff;
		nxt_clksel = clksel_ff;
		nxt_transmit_buffer = transmit_buffer_ff;
		nxt_rdy = apb_acc;
		nxt_err = 1'b0;
		nxt_prdata = 32'h0;
		if (apb_acc)
		begin
			unique case (paddr)
				`CSP_OFF_TXBUF: nxt_prdata = {24'h0, transmit_buffer_ff};
				// data and overrun only, rest zero
				`CSP_OFF_RXBUF: nxt_prdata = {19'h0, overrun_flag_ff, 4'h0, receive_buffer_ff};
				`CSP_OFF_DIV: nxt_prdata = {24'h0, bit_rate_divider_ff};
				`CSP_OFF_MODE: nxt_prdata = {24'h0, mode_ff};
				// shift empty flag at bit 3; bits read zero
				`CSP_OFF_CTRL0: nxt_prdata = {24'h0, ctrl0_ff[7:6], 2'h0, tx_shift_empty_flag, 3'h0};
				`CSP_OFF_CTRL1: nxt_prdata = {24'h0, ctrl1_ff[7:4], rx_complete_flag_ff, ctrl1_ff[2],
					tx_buffer_empty_flag_ff, ctrl1_ff[0]};
				`CSP_OFF_CLKSEL: nxt_prdata = {24'h0, clksel_ff};
				default: nxt_err = 1'b1;
			endcase
			if (pwrite)
			begin
				unique case (paddr)
					`CSP_OFF_TXBUF: nxt_transmit_buffer = pwdata[7:0];
					`CSP_OFF_DIV: nxt_bit_rate_divider = pwdata[7:0];
					`CSP_OFF_MODE: nxt_mode = pwdata[7:0];
					`CSP_OFF_CTRL0: nxt_ctrl0 = {pwdata[7:6], 6'h0};
					`CSP_OFF_CTRL1: nxt_ctrl1 = {pwdata[7:4], 1'b0, pwdata[2], 1'b0, pwdata[0]};
					`CSP_OFF_CLKSEL: nxt_clksel = {5'h0, pwdata[2:0]};
					default: nxt_err = 1'b1;
				endcase
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			bit_rate_divider_ff <= `CSP_DIV_RST;
			mode_ff <= `CSP_MODE_RST;
			ctrl0_ff <= `CSP_CTRL0_RST;
			ctrl1_ff <= `CSP_CTRL1_RST;
			clksel_ff <= `CSP_CLKSEL_RST;
			transmit_buffer_ff <= 8'h00;
			receive_buffer_ff <= 8'h00;
			shift_ff <= 8'h00;
			cnt_ff <= 4'h0;
			div_ff <= 8'h00;
			pre_ff <= 5'h00;
			sck_ff <= 1'b0;
			sdo_ff <= 1'b1;
			overrun_flag_ff <= 1'b0;
			tx_buffer_empty_flag_ff <= 1'b1;
			rx_complete_flag_ff <= 1'b0;
			rx_armed_ff <= 1'b1;
			txev_ff <= 1'b0;
			rxev_ff <= 1'b0;
			rdy_ff <= 1'b0;
			err_ff <= 1'b0;
			prdata_ff <= 32'h0;
			st_ff <= CSP_IDLE;
		end
		else if (clk_en)
		begin
			bit_rate_divider_ff <= nxt_bit_rate_divider;
			mode_ff <= nxt_mode;
			ctrl0_ff <= nxt_ctrl0;
			ctrl1_ff <= nxt_ctrl1;
			clksel_ff <= nxt_clksel;
			transmit_buffer_ff <= nxt_transmit_buffer;
			receive_buffer_ff <= nxt_receive_buffer;
			shift_ff <= nxt_shift;
			cnt_ff <= nxt_cnt;
			div_ff <= nxt_div;
			pre_ff <= nxt_pre;
			sck_ff <= nxt_sck;
			sdo_ff <= nxt_sdo;
			overrun_flag_ff <= nxt_overrun;
			tx_buffer_empty_flag_ff <= nxt_tbe;
			rx_complete_flag_ff <= nxt_rxc;
			rx_armed_ff <= nxt_rx_armed;
			txev_ff <= nxt_txev;
			rxev_ff <= nxt_rxev;
			rdy_ff <= nxt_rdy;
			err_ff <= nxt_err;
			prdata_ff <= nxt_prdata;
			st_ff <= nxt_st;
		end
	end

	assign prdata = prdata_ff;
	assign pready = rdy_ff;
	assign pslverr = err_ff;
	assign tx_event = txev_ff;
	assign rx_event = rxev_ff;
	assign serial_clock_pin_o = sck_ff;
	// drive clock only as master (enable low means driving)
	assign serial_clock_pin_oen = cfg.clock_direction_select;
	assign serial_data_out_pin_o = 1'b0;
	assign serial_data_out_pin_oen = sdo_ff;

	a_start_needs_data: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && st_ff == CSP_IDLE && tx_buffer_empty_flag_ff |=> st_ff != CSP_RUN)
		else $error("transfer started with empty buffer");
	a_shift_empty_idle: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(tx_shift_empty_flag) |-> cnt_ff == 4'h8) else $error("shift empty before last bit");
	a_rx_event_flag: assert property (@(posedge pclk) disable iff (!presetn)
		rx_event |-> rx_complete_flag_ff) else $error("receive event without flag");
	a_slave_no_clock: assert property (@(posedge pclk) disable iff (!presetn)
		cfg.clock_direction_select |-> serial_clock_pin_oen) else $error("slave drove clock");
	a_open_drain: assert property (@(posedge pclk) disable iff (!presetn)
		serial_data_out_pin_o == 1'b0) else $error("data pin driven high");
	a_overrun_sticky: assert property (@(posedge pclk) disable iff (!presetn)
		overrun_flag_ff && !rd_rx |=> overrun_flag_ff) else $error("overrun lost");
	a_load_empties: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && st_ff == CSP_IDLE && nxt_st == CSP_RUN && !(apb_acc && pwrite) |=> tx_buffer_empty_flag_ff)
		else $error("buffer flag not set on load");
	a_rx_needs_en: assert property (@(posedge pclk) disable iff (!presetn)
		rx_event |-> $past(rxen)) else $error("reception without enables");
endmodule

// [bench/csp_far_end.sv]
// Behavioural far-end serial slave for the port's master-mode transfers
`timescale 1ns/1ps
module csp_far_end
(
	input  wire logic       sck,
	input  wire logic       mosi,
	output logic            miso,
	input  wire logic       cpol,
	input  wire logic       cpha,
	input  wire logic       msb,
	input  wire logic       load,
	input  wire logic [7:0] tx_byte,
	output logic      [7:0] rx_byte,
	output int              rx_count
);
	logic       busy;
	logic [7:0] sh;
	logic [7:0] rs;
	int         k;
	int         sb;
	function automatic logic bit_at(input int n);
		return msb ? sh[7 - n] : sh[n];
	endfunction
	initial
	begin
		miso = 1'b1;
		busy = 1'b0;
		rx_count = 0;
		rx_byte = 8'h00;
	end
	always @(posedge load)
	begin
		sh = tx_byte;
		busy = 1'b1;
		k = 0;
		sb = 0;
		if (!cpha)
			miso = bit_at(0);
	end
	always @(sck)
		if (busy)
		begin
			if ((sck != cpol) ^ cpha)
			begin
				rs = msb ? {rs[6:0], mosi} : {mosi, rs[7:1]};
				sb++;
				if (sb == 8)
				begin
					busy = 1'b0;
					rx_byte = rs;
					rx_count++;
					// Released line shows the inverse, not a held value
					miso = ~miso;
				end
			end
			else if (cpha)
			begin
				miso = bit_at(k);
				k++;
			end
			else
			begin
				k++;
				if (k < 8)
					miso = bit_at(k);
			end
		end
endmodule

// [bench/csp_port_tb.sv]
// Self-checking bench: APB access and master-mode transfers against a far-end model
`timescale 1ns/1ps
`include "csp_consts.svh"
module csp_port_tb;
	typedef struct packed {
		logic [31:0] val;
		logic [31:0] msk;
		logic        err;
	} csp_note_t;
	logic        pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic        sck_o, sck_oen, sdo_o, sdo_oen, tx_event, rx_event;
	logic        miso, cpol, cpha, msb, far_load, sck_prev;
	logic [7:0]  far_tx, far_rx;
	int          far_cnt, err_count, checks_done, rx_cnt, edges, hc, half, tx_edge;
	wire         sck_line = sck_oen ? cpol : sck_o;
	// Open-drain data line with pull-up
	wire         mosi = sdo_oen ? 1'b1 : sdo_o;
	csp_note_t   nq[$];
	logic [7:0]  fq[$];
	csp_port i_csp_port (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.serial_clock_pin_i(sck_line), .serial_clock_pin_o(sck_o), .serial_clock_pin_oen(sck_oen),
		.serial_data_in_pin(miso), .serial_data_out_pin_o(sdo_o), .serial_data_out_pin_oen(sdo_oen),
		.tx_event(tx_event), .rx_event(rx_event));
	csp_far_end i_csp_far_end (.sck(sck_line), .mosi(mosi), .miso(miso), .cpol(cpol), .cpha(cpha), .msb(msb),
		.load(far_load), .tx_byte(far_tx), .rx_byte(far_rx), .rx_count(far_cnt));
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		checks_done++;
		if (s !== e)
		begin
			err_count++;
			$display("BAD %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d, input csp_note_t n);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		if (!w)
			nq.push_back(n);
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do
		begin
			@(posedge pclk);
			k++;
		end
		while (pready !== 1'b1 && k < 50);
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1)
		begin
			$display("BAD pready expected 1 seen %b", pready);
			err_count++;
			final_report();
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(a, 1'b1, d, csp_note_t'{32'h0, 32'h0, 1'b0});
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] v, input logic [31:0] m, input logic e);
		apb(a, 1'b0, 32'h0, csp_note_t'{v, m, e});
	endtask
	task automatic xfer(input logic [7:0] t, input logic [7:0] r, input logic [7:0] c1);
		int target;
		int k;
		target = rx_cnt + 1;
		far_tx = r;
		far_load = 1'b1;
		fq.push_back(t ^ {8{c1[7]}});
		edges = 0;
		hc = 0;
		tx_edge = -1;
		@(posedge pclk);
		far_load = 1'b0;
		wr(`CSP_OFF_TXBUF, {24'h0, t});
		if (!c1[0])
		begin
			repeat (40) @(posedge pclk);
			chk("edges_disabled", 32'h0, 32'(edges));
			rd(`CSP_OFF_CTRL1, 32'h0, 32'h02, 1'b0);
			wr(`CSP_OFF_CTRL1, {24'h0, c1 | 8'h01});
		end
		k = 0;
		while (rx_cnt < target && k < 5000)
		begin
			@(posedge pclk);
			k++;
		end
		if (rx_cnt < target)
		begin
			$display("BAD rx_event expected %0d seen %0d", target, rx_cnt);
			err_count++;
			final_report();
		end
	endtask
	initial
	begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end
	always @(posedge pclk)
	begin : apb_mon
		csp_note_t n;
		if (psel && penable && pready === 1'b1 && !pwrite)
		begin
			n = nq.pop_front();
			chk("prdata", n.val & n.msk, prdata & n.msk);
			chk("pslverr", {31'h0, n.err}, {31'h0, pslverr});
		end
	end
	always @(far_cnt)
	begin : far_mon
		logic [7:0] e;
		e = fq.pop_front();
		chk("far_rx", {24'h0, e}, {24'h0, far_rx});
	end
	always @(posedge pclk)
	begin
		hc = hc + 1;
		if (rx_event === 1'b1)
			rx_cnt++;
		if (tx_event === 1'b1)
			tx_edge = edges;
		if (presetn && sck_line !== sck_prev)
		begin
			if (edges > 0 && edges < 16)
				chk("half_period", 32'(half), 32'(hc));
			edges = edges + 1;
			hc = 0;
		end
		sck_prev = sck_line;
	end
	initial
	begin : main
		int i;
		int dn;
		logic inv, irs, src;
		logic [7:0] c1;
		{presetn, psel, penable, pwrite, far_load, cpol, cpha, msb, sck_prev} = '0;
		{paddr, pwdata, far_tx, rx_cnt, err_count, checks_done} = '0;
		clk_en = 1'b1;
		edges = 16;
		half = 1;
		void'($urandom(35253));
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		rd(`CSP_OFF_CTRL0, {24'h0, `CSP_CTRL0_RST}, 32'hff, 1'b0);
		rd(`CSP_OFF_CTRL1, {24'h0, `CSP_CTRL1_RST}, 32'hff, 1'b0);
		rd(`CSP_OFF_DIV, {24'h0, `CSP_DIV_RST}, 32'hff, 1'b0);
		rd(`CSP_OFF_MODE, {24'h0, `CSP_MODE_RST}, 32'hff, 1'b0);
		rd(12'h100, 32'h0, 32'h0, 1'b1);
		$display("test reset_map done");
		for (i = 0; i < 8; i++)
		begin
			{msb, cpha, cpol} = 3'(i);
			inv = cpha ^ msb;
			irs = cpol;
			src = cpol & msb;
			// Receive data passes a two-stage synchroniser: half period must be 3 cycles or more
			dn = 2 + $urandom_range(1);
			half = (dn + 1) * (src ? 2 : 1);
			c1 = {inv, cpha, 1'b0, irs, 3'b010, i != 0};
			wr(`CSP_OFF_MODE, {28'h0, 1'b0, `CSP_MODE_SYNC});
			wr(`CSP_OFF_DIV, 32'(dn));
			wr(`CSP_OFF_CLKSEL, {31'h0, src});
			wr(`CSP_OFF_CTRL0, {24'h0, msb, cpol, 6'h0});
			wr(`CSP_OFF_CTRL1, {24'h0, c1});
			xfer(8'($urandom), 8'hc6 ^ 8'(i), c1);
			rd(`CSP_OFF_RXBUF, {24'h0, 8'hc6 ^ 8'(i) ^ {8{inv}}}, 32'hff, 1'b0);
			rd(`CSP_OFF_CTRL0, 32'h08, 32'h08, 1'b0);
			chk("clock_idle", {31'h0, cpol}, {31'h0, sck_line});
			chk("clock_drive", 32'h0, {31'h0, sck_oen});
			chk("tx_event_edge", {31'h0, irs}, tx_edge < 0 ? 32'h2 : 32'(tx_edge >= 15));
			$display("test transfer %0d done", i);
		end
		xfer(8'h5a, 8'ha5, 8'h01);
		xfer(8'h3c, 8'h96, 8'h01);
		rd(`CSP_OFF_RXBUF, 32'h1000, 32'h1000, 1'b0);
		rd(`CSP_OFF_RXBUF, 32'h0, 32'h1000, 1'b0);
		$display("test overrun done");
		wr(`CSP_OFF_CTRL1, 32'h75);
		xfer(8'h11, 8'h22, 8'h01);
		rd(`CSP_OFF_RXBUF, 32'h22, 32'hff, 1'b0);
		xfer(8'h33, 8'h44, 8'h01);
		rd(`CSP_OFF_RXBUF, 32'h44, 32'hff, 1'b0);
		$display("test continuous done");
		final_report();
	end
endmodule
